// [verilog/occ_map.svh]
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// Register word addresses on the plain register port.
`define OCC_ADDR_CTRL       4'h0
`define OCC_ADDR_PRIMARY    4'h1
`define OCC_ADDR_SECONDARY  4'h2
`define OCC_ADDR_INT_STATUS 4'h3
`define OCC_ADDR_INT_MASK   4'h4

// Control register field positions.
`define OCC_BIT_IDLE_HALT   13
`define OCC_BIT_FAULT       4
`define OCC_BIT_TIME_SEL    3
`define OCC_MODE_MSB        2

// Writable control bits; bit 4 is hardware owned, the rest unimplemented.
`define OCC_CTRL_WR_MASK    16'h200f
`define OCC_CTRL_RESET      16'h0000
`define OCC_CTRL_RSVD_MASK  16'hdfe0

// Interrupt status and mask layout.
`define OCC_INT_COMPARE     0
`define OCC_INT_FAULT       1
`define OCC_INT_RESET       2'h0

// Channels up to this index use fault input A, the rest input B.
`define OCC_FAULT_A_LAST    4

`endif

// [verilog/occ_pkg.sv]
package occ_pkg;

	typedef enum logic [2:0] {
		OCC_MODE_OFF      = 3'h0,
		OCC_MODE_ONE_LOW  = 3'h1,
		OCC_MODE_ONE_HIGH = 3'h2,
		OCC_MODE_TOGGLE   = 3'h3,
		OCC_MODE_DELAYED  = 3'h4,
		OCC_MODE_CONT     = 3'h5,
		OCC_MODE_PWM      = 3'h6,
		OCC_MODE_PWM_FLT  = 3'h7
	} occ_mode_t;

	// Gray coded along idle, armed, high, done.
	typedef enum logic [1:0] {
		OCC_PS_IDLE  = 2'b00,
		OCC_PS_ARMED = 2'b01,
		OCC_PS_HIGH  = 2'b11,
		OCC_PS_DONE  = 2'b10
	} occ_pulse_t;

endpackage : occ_pkg

// [verilog/occ_output_compare_channel.sv]
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "occ_map.svh"

// Summary of operation
// - Mode field in control bits 2:0; zero disables and releases the pin.
// - Mode 001 starts low, compare forces high, interrupt on rising edge.
// - Mode 010 starts high, compare forces low, interrupt on falling edge.
// - Mode 011 keeps level, toggles per compare, interrupts on both edges.
// - Mode 100 starts low, makes one pulse, interrupts on its falling edge.
// - Mode 101 starts low, pulses continuously, interrupts on each falling edge.
// - Mode 110 is PWM ignoring the fault input, with no interrupt.
// - Mode 111 is PWM with fault; channels one to four use input A.
// - Entering PWM drives low if primary compare is zero or mode 111 keeps a latched fault, else high.
// - Read-only fault flag at bit 4, set on PWM fault, hardware cleared.
// - Bit 3 selects third timer when set, second timer when clear.
// - Bit 13 set halts the channel while the CPU is idle.
// - Control bits 15:14 and 12:5 ignore writes and read zero.
// - Output changes when the selected timer matches a compare register.
// - Channels five to eight use fault input B in fault PWM mode.
module occ_output_compare_channel #(
	parameter int CHANNEL_INDEX = 1
) (
	input  wire logic        sys_clk,        // System clock, 25 MHz.
	input  wire logic        rstn,           // Asynchronous reset, active low.
	input  wire logic [3:0]  regAddr,        // Register word address.
	input  wire logic [15:0] regWrData,      // Register write data.
	input  wire logic        regWr,          // Write strobe.
	input  wire logic        regRd,          // Read strobe.
	output logic      [15:0] regRdData,      // Read data, cycle after strobe.
	input  wire logic [15:0] timer2Count,    // Second general timer count.
	input  wire logic [15:0] timer3Count,    // Third general timer count.
	input  wire logic        cpuIdle,        // CPU is in Idle mode.
	input  wire logic        faultInputAN,   // Fault input A pin, active low.
	input  wire logic        faultInputBN,   // Fault input B pin, active low.
	output logic             compareOutPin,  // Compare output pin level.
	output logic             compareOutEn,   // Pin owned by the channel.
	output logic             irq             // Level interrupt.
);
	import occ_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release and fault pin synchronisers.

	logic       rstMeta_q;
	logic       rstnSync;
	logic [1:0] faultMeta_q;
	logic [1:0] faultSync_q;
	logic       faultPrev_q;
	logic       faultOkN;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstnSync  <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstnSync  <= rstMeta_q;
		end
	end

	// Idle level of the fault pins is high, so that is the reset value.
	always_ff @(posedge sys_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			faultMeta_q <= 2'h3;
			faultSync_q <= 2'h3;
			faultPrev_q <= 1'b1;
		end else begin
			faultMeta_q <= {faultInputBN, faultInputAN};
			faultSync_q <= faultMeta_q;
			faultPrev_q <= faultOkN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and channel state.

	logic [15:0] ctrl_q, ctrl_d;
	logic [15:0] primary_q, primary_d;
	logic [15:0] secondary_q, secondary_d;
	logic [15:0] duty_q, duty_d;
	logic [15:0] prevBase_q;
	logic [1:0]  intStatus_q, intStatus_d;
	logic [1:0]  intMask_q, intMask_d;
	logic [15:0] rdData_q, rdData_d;
	logic        out_q, out_d;
	logic        outEn_q, outEn_d;
	logic        irq_q, irq_d;
	occ_pulse_t  pulse_q, pulse_d;

	occ_mode_t   mode;
	logic [15:0] timeBase;
	logic [1:0]  clearBits;
	logic        advanced, matchPri, matchSec, matchDuty, rollover;
	logic        halted, faultFall, ctrlWr, opOut, initOut;
	logic        evCompare, evFault, faultSet;

	assign mode = occ_mode_t'(ctrl_q[`OCC_MODE_MSB:0]);
	assign timeBase = ctrl_q[`OCC_BIT_TIME_SEL] ? timer3Count : timer2Count;
	// Matches count only when the time base moves, so a stopped
	// timer sitting on the compare value does not retrigger every cycle.
	assign advanced  = timeBase != prevBase_q;
	assign matchPri  = advanced && (timeBase == primary_q);
	assign matchSec  = advanced && (timeBase == secondary_q);
	assign matchDuty = advanced && (timeBase == duty_q);
	assign rollover  = advanced && (timeBase == 16'h0000);
	assign halted = ctrl_q[`OCC_BIT_IDLE_HALT] && cpuIdle;
	assign faultOkN  = (CHANNEL_INDEX <= `OCC_FAULT_A_LAST) ?
		faultSync_q[0] : faultSync_q[1];
	assign faultFall = faultPrev_q && !faultOkN;
	assign ctrlWr    = regWr && (regAddr == `OCC_ADDR_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Compare engine: next output and pulse state from the mode.

	always_comb begin
		opOut    = out_q;
		pulse_d  = pulse_q;
		duty_d   = duty_q;
		faultSet = 1'b0;
		if (!halted) begin
			case (mode)
				OCC_MODE_OFF:      opOut = 1'b0;
				OCC_MODE_ONE_LOW:  if (matchPri) opOut = 1'b1;
				OCC_MODE_ONE_HIGH: if (matchPri) opOut = 1'b0;
				OCC_MODE_TOGGLE:   if (matchPri) opOut = !out_q;
				OCC_MODE_DELAYED, OCC_MODE_CONT: begin
					case (pulse_q)
						OCC_PS_ARMED: begin
							if (matchPri) begin
								opOut   = 1'b1;
								pulse_d = OCC_PS_HIGH;
							end
						end
						OCC_PS_HIGH: begin
							if (matchSec) begin
								opOut   = 1'b0;
								pulse_d = (mode == OCC_MODE_CONT) ?
									OCC_PS_ARMED : OCC_PS_DONE;
							end
						end
						default: opOut = 1'b0;
					endcase
				end
				// PWM from rollover and latched duty
				default: begin
					if (rollover) begin
						duty_d = secondary_q;
						opOut  = secondary_q != 16'h0000;
					end else if (matchDuty) begin
						opOut = 1'b0;
					end
					if (mode == OCC_MODE_PWM_FLT &&
						(!faultOkN || ctrl_q[`OCC_BIT_FAULT])) begin
						opOut    = 1'b0;
						faultSet = !faultOkN;
					end
				end
			endcase
		end
	end

	always_comb begin
		evCompare = 1'b0;
		if (!halted && !ctrlWr) begin
			case (mode)
				OCC_MODE_ONE_LOW: evCompare = !out_q && opOut;
				OCC_MODE_TOGGLE:  evCompare = out_q != opOut;
				OCC_MODE_ONE_HIGH, OCC_MODE_DELAYED, OCC_MODE_CONT:
					evCompare = out_q && !opOut;
				default:          evCompare = 1'b0;
			endcase
		end
	end

	assign evFault = !halted && (mode == OCC_MODE_PWM_FLT) && faultFall;

	always_comb begin
		case (occ_mode_t'(regWrData[`OCC_MODE_MSB:0]))
			OCC_MODE_ONE_HIGH: initOut = 1'b1;
			OCC_MODE_TOGGLE:   initOut = out_q;
			OCC_MODE_PWM, OCC_MODE_PWM_FLT:
				initOut = primary_q != 16'h0000;
			default:           initOut = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register port, control writes and interrupt status.

	always_comb begin
		ctrl_d      = ctrl_q;
		primary_d   = primary_q;
		secondary_d = secondary_q;
		intMask_d   = intMask_q;
		clearBits   = 2'h0;
		out_d       = opOut;
		rdData_d    = 16'h0000;
		if (faultSet) begin
			ctrl_d[`OCC_BIT_FAULT] = 1'b1;
		end
		if (regWr) begin
			if (regAddr == `OCC_ADDR_CTRL) begin
				// Only implemented bits take the write.
				ctrl_d = (regWrData & `OCC_CTRL_WR_MASK) |
					(ctrl_d & ~(`OCC_CTRL_WR_MASK));
				// Rewriting the mode releases the lock once clear.
				if (faultOkN) ctrl_d[`OCC_BIT_FAULT] = 1'b0;
				// Entry under a latched fault stays low.
				out_d = initOut && !(ctrl_d[`OCC_BIT_FAULT] &&
					ctrl_d[`OCC_MODE_MSB:0] == 3'h7);
			end else if (regAddr == `OCC_ADDR_PRIMARY) begin
				primary_d = regWrData;
			end else if (regAddr == `OCC_ADDR_SECONDARY) begin
				secondary_d = regWrData;
			end else if (regAddr == `OCC_ADDR_INT_STATUS) begin
				clearBits = regWrData[1:0];
			end else if (regAddr == `OCC_ADDR_INT_MASK) begin
				intMask_d = regWrData[1:0];
			end
		end
		if (regRd) begin
			if (regAddr == `OCC_ADDR_CTRL) begin
				rdData_d = ctrl_q;
			end else if (regAddr == `OCC_ADDR_PRIMARY) begin
				rdData_d = primary_q;
			end else if (regAddr == `OCC_ADDR_SECONDARY) begin
				rdData_d = secondary_q;
			end else if (regAddr == `OCC_ADDR_INT_STATUS) begin
				rdData_d = {14'h0000, intStatus_q};
			end else if (regAddr == `OCC_ADDR_INT_MASK) begin
				rdData_d = {14'h0000, intMask_q};
			end
		end
		// A new event wins over a write-one-to-clear in the same cycle.
		intStatus_d = (intStatus_q & ~clearBits) | {evFault, evCompare};
		// Disabled channel hands the pin back to the port logic.
		outEn_d = ctrl_d[`OCC_MODE_MSB:0] != OCC_MODE_OFF;
		irq_d   = |(intStatus_d & intMask_d);
	end

	// Pulse sequencer restarts from armed on any control write.
	occ_pulse_t pulseNext;
	assign pulseNext = ctrlWr ? OCC_PS_ARMED : pulse_d;

	always_ff @(posedge sys_clk or negedge rstnSync) begin
		if (!rstnSync) begin
			ctrl_q      <= `OCC_CTRL_RESET;
			primary_q   <= 16'h0000;
			secondary_q <= 16'h0000;
			duty_q      <= 16'h0000;
			prevBase_q  <= 16'h0000;
			intStatus_q <= `OCC_INT_RESET;
			intMask_q   <= `OCC_INT_RESET;
			rdData_q    <= 16'h0000;
			out_q       <= 1'b0;
			outEn_q     <= 1'b0;
			irq_q       <= 1'b0;
			pulse_q     <= OCC_PS_IDLE;
		end else begin
			ctrl_q      <= ctrl_d;
			primary_q   <= primary_d;
			secondary_q <= secondary_d;
			duty_q      <= duty_d;
			prevBase_q  <= timeBase;
			intStatus_q <= intStatus_d;
			intMask_q   <= intMask_d;
			rdData_q    <= rdData_d;
			out_q       <= out_d;
			outEn_q     <= outEn_d;
			irq_q       <= irq_d;
			pulse_q     <= pulseNext;
		end
	end

	assign regRdData     = rdData_q;
	assign compareOutPin = out_q;
	assign compareOutEn  = outEn_q;
	assign irq           = irq_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstnSync);

	logic run;
	assign run = !halted && !ctrlWr;

	property p_off_released;
		compareOutEn == (ctrl_q[`OCC_MODE_MSB:0] != 3'h0);
	endproperty
	a_off_released: assert property (p_off_released)
		else $error("pin enable does not follow mode field");

	property p_one_low_rise;
		mode == OCC_MODE_ONE_LOW && run && matchPri && !compareOutPin
			|=> compareOutPin && intStatus_q[`OCC_INT_COMPARE];
	endproperty
	a_one_low_rise: assert property (p_one_low_rise)
		else $error("one-shot low did not rise with interrupt");

	property p_one_high_fall;
		mode == OCC_MODE_ONE_HIGH && run && matchPri
			|=> !compareOutPin;
	endproperty
	a_one_high_fall: assert property (p_one_high_fall)
		else $error("one-shot high did not fall on compare");

	property p_toggle;
		mode == OCC_MODE_TOGGLE && run && matchPri
			|=> compareOutPin != $past(compareOutPin) &&
				intStatus_q[`OCC_INT_COMPARE];
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle mode did not invert output");

	sequence s_pulse_end;
		pulse_q == OCC_PS_HIGH && run && matchSec;
	endsequence

	property p_delayed_single;
		(mode == OCC_MODE_DELAYED) ##0 s_pulse_end
			|=> !compareOutPin && pulse_q == OCC_PS_DONE &&
				intStatus_q[`OCC_INT_COMPARE];
	endproperty
	a_delayed_single: assert property (p_delayed_single)
		else $error("delayed one-shot did not end in done");

	property p_cont_rearm;
		(mode == OCC_MODE_CONT) ##0 s_pulse_end
			|=> !compareOutPin && pulse_q == OCC_PS_ARMED;
	endproperty
	a_cont_rearm: assert property (p_cont_rearm)
		else $error("continuous pulse did not rearm");

	property p_pwm_no_irq;
		mode == OCC_MODE_PWM && !ctrlWr
			|=> !$rose(intStatus_q[`OCC_INT_COMPARE]) &&
				!$rose(intStatus_q[`OCC_INT_FAULT]);
	endproperty
	a_pwm_no_irq: assert property (p_pwm_no_irq)
		else $error("interrupt raised in plain PWM mode");

	property p_fault_force;
		mode == OCC_MODE_PWM_FLT && !halted && !faultOkN &&
			(!ctrlWr || regWrData[`OCC_MODE_MSB:0] == 3'h7)
			|=> !compareOutPin && ctrl_q[`OCC_BIT_FAULT];
	endproperty
	a_fault_force: assert property (p_fault_force)
		else $error("fault did not force output low and set flag");

	sequence s_pwm_entry;
		ctrlWr && regWrData[`OCC_MODE_MSB:1] == 2'h3;
	endsequence

	property p_pwm_entry;
		s_pwm_entry |=> compareOutPin == ($past(primary_q) != 16'h0000 &&
			!(ctrl_q[`OCC_BIT_FAULT] && mode == OCC_MODE_PWM_FLT));
	endproperty
	a_pwm_entry: assert property (p_pwm_entry)
		else $error("PWM entry level wrong");

	property p_idle_halt;
		halted && !ctrlWr |=> $stable(compareOutPin);
	endproperty
	a_idle_halt: assert property (p_idle_halt)
		else $error("output moved while halted in idle");

	property p_reserved_zero;
		regRd && regAddr == `OCC_ADDR_CTRL
			|=> (regRdData & `OCC_CTRL_RSVD_MASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bits read nonzero");

endmodule : occ_output_compare_channel

`default_nettype wire

// [dv/occ_pin_partner.sv]
`timescale 1ns/100ps
`default_nettype none

// Board circuit on the compare pin: edge counter plus two fault lines.
module occ_pin_partner (
	input  wire logic       sys_clk,   // Clock.
	input  wire logic       rstn,      // Reset, active low.
	input  wire logic       pinLevel,  // Compare output pin level.
	input  wire logic       pinEn,     // Pin driven by the channel.
	input  wire logic       faultAReq, // Pull fault line A low.
	input  wire logic       faultBReq, // Pull fault line B low.
	output logic            faultAN,   // Fault line A, pulled up.
	output logic            faultBN,   // Fault line B, pulled up.
	output logic      [7:0] riseCount, // Rising pin edges seen.
	output logic      [7:0] fallCount  // Falling pin edges seen.
);
	logic lastLevel;

	// Open-drain lines float back to the pull-up once released.
	assign faultAN = !faultAReq;
	assign faultBN = !faultBReq;

	////////////////////////////////////////////////////////////////////////
	// Edges are only counted while the channel owns the pin.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lastLevel <= 1'b0;
			riseCount <= 8'h00;
			fallCount <= 8'h00;
		end else if (pinEn) begin
			lastLevel <= pinLevel;
			riseCount <= riseCount + 8'(pinLevel && !lastLevel);
			fallCount <= fallCount + 8'(!pinLevel && lastLevel);
		end
	end
endmodule : occ_pin_partner

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "occ_map.svh"

module testbench;
	import occ_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdData;
	logic [15:0] timer2Count = 16'h0000;
	logic [15:0] timer3Count = 16'h0000;
	logic        cpuIdle = 1'b0;
	logic        faultAReq = 1'b0;
	logic        faultBReq = 1'b0;
	logic        faultAN, faultBN, compareOutPin, compareOutEn, irq;
	logic [7:0]  riseCount, fallCount, rise0, fall0;
	logic [15:0] expQ[$];
	logic        rdSeen = 1'b0;
	logic [15:0] prim;
	int          failures = 0;
	int          samples_checked = 0;

	always #20 sys_clk = ~sys_clk;

	occ_output_compare_channel #(.CHANNEL_INDEX(1)) i_occ_output_compare_channel (
		.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .timer2Count(timer2Count),
		.timer3Count(timer3Count), .cpuIdle(cpuIdle),
		.faultInputAN(faultAN), .faultInputBN(faultBN),
		.compareOutPin(compareOutPin), .compareOutEn(compareOutEn), .irq(irq));

	occ_pin_partner i_occ_pin_partner (
		.sys_clk(sys_clk), .rstn(rstn), .pinLevel(compareOutPin),
		.pinEn(compareOutEn), .faultAReq(faultAReq), .faultBReq(faultBReq),
		.faultAN(faultAN), .faultBN(faultBN),
		.riseCount(riseCount), .fallCount(fallCount));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] e,
			input string m);
		samples_checked++;
		if (got !== e) begin
			failures++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// Strobe is dropped and an edge passes, so no signal is set twice at once.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		expQ.push_back(e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(posedge sys_clk);
	endtask : rd

	// Timer counts are held still whenever control is rewritten.
	// timer stopped first
	task automatic setm(input logic [15:0] d);
		wr(`OCC_ADDR_CTRL, d);
		@(posedge sys_clk);
	endtask : setm

	task automatic tick(input bit sel, input int top);
		for (int v = 0; v <= top; v++) begin
			if (sel)
				timer3Count <= 16'(v);
			else
				timer2Count <= 16'(v);
			@(posedge sys_clk);
		end
		repeat (2) @(posedge sys_clk);
	endtask : tick

	// Looks at enable, pin and irq away from the edge that updates them.
	task automatic pchk(input logic [2:0] e, input string m);
		@(negedge sys_clk);
		chk(16'({compareOutEn, compareOutPin, irq}), 16'(e), m);
		@(posedge sys_clk);
	endtask : pchk

	task automatic clr(input string m);
		wr(`OCC_ADDR_INT_STATUS, 16'h0003);
		$display("test %s done", m);
	endtask : clr

	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		if (rdSeen)
			chk(regRdData, expQ.pop_front(), "read data");
		rdSeen <= regRd;
	end

	initial begin
		#200000;
		failures++;
		$display("FAIL %0t run did not finish", $time);
		test_done();
	end

	initial begin
		void'($urandom(32'h12132b32));
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(`OCC_ADDR_CTRL, 16'h0000);
		rd(`OCC_ADDR_INT_STATUS, 16'h0000);
		rd(4'hf, 16'h0000);
		wr(4'hf, 16'hffff);
		setm(16'hffff);
		rd(`OCC_ADDR_CTRL, 16'h200f);
		pchk(3'b100, "enable in mode 7");
		setm(16'h0000);
		pchk(3'b000, "disabled pin");
		clr("registers");
		prim = 16'(3 + $urandom % 5);
		wr(`OCC_ADDR_PRIMARY, prim);
		wr(`OCC_ADDR_SECONDARY, prim + 16'h0003);
		wr(`OCC_ADDR_INT_MASK, 16'h0000);
		setm(16'h0001);
		pchk(3'b100, "mode 1 entry");
		tick(0, 12);
		pchk(3'b110, "mode 1 masked");
		rd(`OCC_ADDR_INT_STATUS, 16'h0001);
		wr(`OCC_ADDR_INT_MASK, 16'h0003);
		pchk(3'b111, "irq unmasked");
		wr(`OCC_ADDR_INT_STATUS, 16'h0001);
		pchk(3'b110, "irq cleared");
		clr("mode1");
		setm(16'h0002);
		pchk(3'b110, "mode 2 entry");
		tick(0, 12);
		pchk(3'b101, "mode 2 compare");
		clr("mode2");
		setm(16'h0003);
		pchk(3'b100, "toggle keeps level");
		tick(0, 12);
		pchk(3'b111, "toggle rise");
		clr("toggle rise");
		tick(0, 12);
		pchk(3'b101, "toggle fall");
		clr("toggle");
		setm(16'h0004);
		rise0 = riseCount;
		fall0 = fallCount;
		repeat (3) tick(0, 12);
		chk(16'(riseCount - rise0), 16'h0001, "single pulse rise");
		chk(16'(fallCount - fall0), 16'h0001, "single pulse fall");
		pchk(3'b101, "single pulse irq");
		clr("delayed");
		setm(16'h0005);
		rise0 = riseCount;
		fall0 = fallCount;
		repeat (3) tick(0, 12);
		chk(16'(riseCount - rise0), 16'h0003, "pulse train rise");
		chk(16'(fallCount - fall0), 16'h0003, "pulse train fall");
		pchk(3'b101, "pulse train irq");
		clr("continuous");
		setm(16'h0009);
		tick(0, 12);
		pchk(3'b100, "other timer ignored");
		tick(1, 12);
		pchk(3'b111, "third timer match");
		clr("timer select");
		setm(16'h2001);
		cpuIdle <= 1'b1;
		tick(0, 12);
		pchk(3'b100, "halted in idle");
		cpuIdle <= 1'b0;
		tick(0, 12);
		pchk(3'b111, "runs after idle");
		clr("idle");
		wr(`OCC_ADDR_PRIMARY, 16'h0001);
		wr(`OCC_ADDR_SECONDARY, 16'h0004);
		setm(16'h0006);
		pchk(3'b110, "pwm entry high");
		faultAReq <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pchk(3'b110, "fault ignored");
		faultAReq <= 1'b0;
		rise0 = riseCount;
		fall0 = fallCount;
		repeat (2) tick(0, 9);
		chk(16'(riseCount - rise0), 16'h0001, "pwm rise");
		chk(16'(fallCount - fall0), 16'h0002, "pwm fall");
		rd(`OCC_ADDR_INT_STATUS, 16'h0000);
		wr(`OCC_ADDR_PRIMARY, 16'h0000);
		setm(16'h0006);
		pchk(3'b100, "pwm entry low");
		clr("pwm");
		wr(`OCC_ADDR_PRIMARY, 16'h0001);
		setm(16'h0007);
		faultBReq <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pchk(3'b110, "fault B ignored");
		faultBReq <= 1'b0;
		faultAReq <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pchk(3'b101, "fault A forces low");
		rd(`OCC_ADDR_CTRL, 16'h0017);
		rd(`OCC_ADDR_INT_STATUS, 16'h0002);
		faultAReq <= 1'b0;
		repeat (6) @(posedge sys_clk);
		pchk(3'b101, "held low after fault");
		clr("fault held");
		setm(16'h0007);
		rd(`OCC_ADDR_CTRL, 16'h0007);
		pchk(3'b110, "fault recovered");
		clr("fault");
		test_done();
	end
endmodule : testbench

`default_nettype wire
